//--- design/hsc_regs.sv
/*
  hsc_regs: string-area and downstream charge-enable register bank.
  holds the three string length bytes, the per-port charge enable byte
  and, through u_text, the three string areas.
  string bytes are kept exactly as written; pairing and order of the
  UTF-16LE characters are the master's duty.
  reads answer one pending cycle after they are taken.
  assumes a byte-wide write/read port from a serial config slave
  and one clock for the whole bank.
*/
`timescale 1ns/1ps
// Operation
// R1 - manufacturer text bytes sit at 16H..53H and reset to zero.
// R2 - product text bytes sit at 54H..91H and reset to zero.
// R3 - serial text bytes sit at 92H..CFH and reset to zero.
// R4 - each area holds UTF-16LE characters for a string descriptor.
// R5 - the master writes each character low byte first, high byte next.
// R6 - the master stores characters contiguously without gaps.
// R7 - charge enable at D0 resets to zero, bits 1..3 map to ports 1..3.
// R8 - a set enable bit turns on charging support for that port.
// R9 - string length bytes at 13H, 14H, 15H reset to zero.
// R10 - reserved charge-enable bits ignore writes and read as zero.
module hsc_regs
  import hsc_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          cfg_wr,
  input  wire logic                          cfg_rd,
  input  wire logic [hsc_pkg::ADDR_W-1:0]    cfg_addr,
  input  wire logic [hsc_pkg::DATA_W-1:0]    cfg_wdata,
  output logic      [hsc_pkg::DATA_W-1:0]    cfg_rdata,
  output logic                               cfg_rvalid,
  output logic      [hsc_pkg::NUM_PORTS-1:0] charge_port_en,
  output logic      [7:0]                    manufacturer_text_length,
  output logic      [7:0]                    product_text_length,
  output logic      [7:0]                    serial_text_length
);
  // one select value per register or string area
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MLEN,
    SEL_PLEN,
    SEL_SLEN,
    SEL_MTXT,
    SEL_PTXT,
    SEL_STXT,
    SEL_CHG
  } hsc_sel_t;

  typedef struct packed {
    logic [7:0] mlen;    // string length registers
    logic [7:0] plen;
    logic [7:0] slen;
    logic [7:0] chg;     // reserved bits held at zero
    logic       rd_pend; // read taken, answer due next edge
    hsc_sel_t   rd_sel;  // select captured with the read
    logic [7:0] rdata;
    logic       rvalid;
  } hsc_state_t;

  hsc_state_t st_ff;
  hsc_state_t nxt_st;
  hsc_sel_t   sel;
  logic       text_hit;
  logic       wr_take;
  logic       rd_take;
  logic [7:0] chg_wval;

  // byte port into the string store
  hsc_cfg_if text_if ();

  // inclusive address window test
  function automatic logic in_span(input logic [7:0] a,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction

  // if-else chain: length bytes first, then the area ranges
  function automatic hsc_sel_t decode(input logic [7:0] a);
    if (a == MFR_LEN_ADDR) begin
      decode = SEL_MLEN;
    end else if (a == PRD_LEN_ADDR) begin
      decode = SEL_PLEN;
    end else if (a == SER_LEN_ADDR) begin
      decode = SEL_SLEN;
    end else if (in_span(a, MFR_TEXT_FIRST, MFR_TEXT_LAST)) begin
      decode = SEL_MTXT; // see R1
    end else if (in_span(a, PRD_TEXT_FIRST, PRD_TEXT_LAST)) begin
      decode = SEL_PTXT; // see R2
    end else if (in_span(a, SER_TEXT_FIRST, SER_TEXT_LAST)) begin
      decode = SEL_STXT; // see R3
    end else if (a == CHARGE_EN_ADDR) begin
      decode = SEL_CHG;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // any of the three string areas
  function automatic logic is_text(input hsc_sel_t s);
    is_text = (s == SEL_MTXT) || (s == SEL_PTXT) || (s == SEL_STXT);
  endfunction

  // areas sit back to back, so one base maps all three into the store
  function automatic logic [7:0] text_index(input logic [7:0] a,
                                            input hsc_sel_t   s);
    if (is_text(s)) begin
      text_index = 8'(a - MFR_TEXT_FIRST);
    end else begin
      text_index = 8'h00;
    end
  endfunction

  // registered read value for a captured select
  function automatic logic [7:0] rd_value(input hsc_sel_t   s,
                                          input hsc_state_t st,
                                          input logic [7:0] tbyte);
    case (s)
      SEL_MLEN: begin
        rd_value = st.mlen; // see R9
      end
      SEL_PLEN: begin
        rd_value = st.plen; // see R9
      end
      SEL_SLEN: begin
        rd_value = st.slen; // see R9
      end
      SEL_MTXT: begin
        rd_value = tbyte; // see R1
      end
      SEL_PTXT: begin
        rd_value = tbyte; // see R2
      end
      SEL_STXT: begin
        rd_value = tbyte; // see R3
      end
      SEL_CHG: begin
        rd_value = st.chg & CHARGE_EN_MASK; // see R10
      end
      default: begin
        rd_value = RESET_BYTE;
      end
    endcase
  endfunction

  assign sel           = decode(cfg_addr);
  assign text_hit      = is_text(sel);
  assign wr_take       = cfg_wr;
  // a write wins a same-cycle clash; the read is dropped
  assign rd_take       = cfg_rd && !cfg_wr;
  assign chg_wval      = cfg_wdata & CHARGE_EN_MASK; // see R10
  assign text_if.we    = wr_take && text_hit;
  assign text_if.idx   = text_index(cfg_addr, sel);
  assign text_if.wdata = cfg_wdata;

  hsc_text_store u_text (
    .clk    (clk),
    .resetn (resetn),
    .cfg    (text_if.store)
  );

  // write side first, then the read answer
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;
    if (wr_take) begin
      case (sel)
        SEL_MLEN: begin
          nxt_st.mlen = cfg_wdata; // see R9
        end
        SEL_PLEN: begin
          nxt_st.plen = cfg_wdata; // see R9
        end
        SEL_SLEN: begin
          nxt_st.slen = cfg_wdata; // see R9
        end
        SEL_MTXT, SEL_PTXT, SEL_STXT: begin
          // the byte goes to u_text through text_if.we; see R4
        end
        SEL_CHG: begin
          nxt_st.chg = chg_wval; // see R7 R10
        end
        default: begin
        end
      endcase
    end

    // read taken at edge N: select captured, store looks the byte up;
    // edge N+1 registers the answer with a one-cycle rvalid
    nxt_st.rd_pend = rd_take;
    nxt_st.rd_sel  = sel;
    if (st_ff.rd_pend) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_value(st_ff.rd_sel, st_ff, text_if.rdata);
    end
  end

  // whole state in one register, cleared together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0; // see R7 R9
    end else begin
      st_ff <= nxt_st;
    end
  end

  // port n follows enable bit n; bit 0 is reserved
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign charge_port_en[gp] = st_ff.chg[gp+1]; // see R8
    end
  endgenerate

  // outputs straight from the state register
  assign cfg_rdata                = st_ff.rdata;
  assign cfg_rvalid               = st_ff.rvalid;
  assign manufacturer_text_length = st_ff.mlen;
  assign product_text_length      = st_ff.plen;
  assign serial_text_length       = st_ff.slen;
endmodule

//--- design/hsc_pkg.sv
/*
  hsc_pkg: constants for the hub string and charge-enable register bank.
  assumes byte-wide config port with 8-bit register addresses.
*/
package hsc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] MFR_LEN_ADDR     = 8'h13;
  localparam logic [7:0] PRD_LEN_ADDR     = 8'h14;
  localparam logic [7:0] SER_LEN_ADDR     = 8'h15;
  localparam logic [7:0] MFR_TEXT_FIRST   = 8'h16;
  localparam logic [7:0] MFR_TEXT_LAST    = 8'h53;
  localparam logic [7:0] PRD_TEXT_FIRST   = 8'h54;
  localparam logic [7:0] PRD_TEXT_LAST    = 8'h91;
  localparam logic [7:0] SER_TEXT_FIRST   = 8'h92;
  localparam logic [7:0] SER_TEXT_LAST    = 8'hcf;
  localparam logic [7:0] CHARGE_EN_ADDR   = 8'hd0;
  localparam int unsigned TEXT_BYTES      = 186;
  localparam logic [7:0] CHARGE_EN_MASK   = 8'h0e;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam int unsigned NUM_PORTS       = 3;
  localparam int unsigned TEXT_IDX_W      = 8;
endpackage

//--- design/hsc_cfg_if.sv
/*
  hsc_cfg_if: internal byte write/read port between decode and store.
  assumes one clock; the top module drives the bus side.
*/
`timescale 1ns/1ps
interface hsc_cfg_if;
  logic       we;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl  (output we, output idx, output wdata, input rdata);
  modport store (input we, input idx, input wdata, output rdata);
endinterface

//--- design/hsc_text_store.sv
/*
  hsc_text_store: byte array holding the three descriptor string areas.
  assumes index 0 maps to the first manufacturer byte.
*/
`timescale 1ns/1ps
module hsc_text_store
  import hsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  hsc_cfg_if.store  cfg
);
  typedef struct packed {
    logic [TEXT_BYTES-1:0][7:0] mem;
    logic [7:0]                 rd;
  } hsc_store_t;

  hsc_store_t st_ff;
  hsc_store_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // each byte keeps whatever the master wrote; pairing is the master's job
    if (cfg.we && (int'(cfg.idx) < TEXT_BYTES)) begin // see R4
      nxt_st.mem[cfg.idx] = cfg.wdata;
    end
    if (int'(cfg.idx) < TEXT_BYTES) begin
      nxt_st.rd = st_ff.mem[cfg.idx];
    end else begin
      nxt_st.rd = RESET_BYTE;
    end
  end

  // every text byte clears to zero; see R1 R2 R3
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg.rdata = st_ff.rd;
endmodule

//--- tb/hsc_cfg_master.sv
/* master model for hsc_regs config port; assumes regs timing. */
`timescale 1ns/1ps
module hsc_cfg_master (
  input  wire logic       clk,
  output logic            cfg_wr,
  output logic            cfg_rd,
  output logic      [7:0] cfg_addr,
  output logic      [7:0] cfg_wdata,
  input  wire logic [7:0] cfg_rdata,
  input  wire logic       cfg_rvalid
);
  initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = '0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    {cfg_wr, cfg_wdata} <= {1'b0, ~d};
    #1;
  endtask
  task automatic wchar(input logic [7:0] a, input logic [15:0] c);
    wr(a, c[7:0]);
    wr(a + 8'h01, c[15:8]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge clk);
    {cfg_rd, cfg_addr} <= {1'b0, ~a};
    @(posedge clk);
    #1 d = (cfg_rvalid === 1'b1) ? cfg_rdata : 8'hxx;
  endtask
endmodule

//--- tb/hsc_regs_checker.sv
/* port assertions for hsc_regs; bound to it below. */
`timescale 1ns/1ps
module hsc_regs_checker
  import hsc_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       cfg_rvalid,
  input wire logic [2:0] charge_port_en,
  input wire logic [7:0] manufacturer_text_length
);
  logic [2:0] wen;
  assign wen = cfg_wdata[3:1];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence rd_to(logic [7:0] x); cfg_rd && !cfg_wr && cfg_addr == x; endsequence
  sequence wr_to(logic [7:0] x); cfg_wr && cfg_addr == x; endsequence
  chk_read_answer: assert property (cfg_rd && !cfg_wr |-> ##2 cfg_rvalid)
    else $error("read unanswered");
  chk_answer_due: assert property (cfg_rvalid |-> $past(cfg_rd, 2))
    else $error("stray rvalid");
  chk_rdata_hold: assert property (!cfg_rvalid |-> $stable(cfg_rdata))
    else $error("rdata moved");
  chk_en_write: assert property (wr_to(CHARGE_EN_ADDR) |=>
    charge_port_en == $past(wen)) else $error("port enable not written");
  chk_en_hold: assert property (!cfg_wr |=> $stable(charge_port_en))
    else $error("port enable moved");
  chk_len_write: assert property (wr_to(MFR_LEN_ADDR) |=>
    manufacturer_text_length == $past(cfg_wdata)) else $error("length");
  chk_len_hold: assert property (!cfg_wr |=> $stable(manufacturer_text_length))
    else $error("length moved");
  chk_rsvd_zero: assert property (rd_to(CHARGE_EN_ADDR) |->
    ##2 (cfg_rdata & 8'hf1) == 8'h00) else $error("reserved bits set");
endmodule
bind hsc_regs hsc_regs_checker u_chk (
  .clk                      (clk),
  .resetn                   (resetn),
  .cfg_wr                   (cfg_wr),
  .cfg_rd                   (cfg_rd),
  .cfg_addr                 (cfg_addr),
  .cfg_wdata                (cfg_wdata),
  .cfg_rdata                (cfg_rdata),
  .cfg_rvalid               (cfg_rvalid),
  .charge_port_en           (charge_port_en),
  .manufacturer_text_length (manufacturer_text_length)
);

//--- tb/hsc_regs_test.sv
/* bench for hsc_regs; assumes master model and bound checker. */
`timescale 1ns/1ps
module hsc_regs_test;
  import hsc_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, d, x, manufacturer_text_length;
  logic [7:0]  product_text_length, serial_text_length;
  logic [2:0]  charge_port_en, ep = 3'h0;
  logic [15:0] s = 16'h1ec9;
  int          n_mismatch = 0, cmp_count = 0;
  logic [7:0]  t [12] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h52, 8'h54,
                          8'h90, 8'h92, 8'hce, 8'hd0, 8'h12, 8'hd1};
  always #25 clk = ~clk;
  hsc_cfg_master u_mst (.*);
  hsc_regs u_dut (.*);
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, v);
    if (ad == CHARGE_EN_ADDR) return v & 8'h0e;
    return (ad >= MFR_LEN_ADDR && ad <= SER_TEXT_LAST) ? v : 8'h00;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, e);
    u_mst.rd(ad, d);
    chk("rdata", e, d);
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    foreach (t[i]) rchk(t[i], 8'h00);
    $display("reset test done");
    for (int i = 3; i < 9; i++) begin
      s = lfsr(s);
      u_mst.wchar(t[i], s);
      rchk(t[i], s[7:0]);
      rchk(t[i] + 8'h01, s[15:8]);
    end
    $display("text test done");
    for (int i = 0; i < 36; i++) begin
      s = lfsr(s);
      x = (i < 12) ? 8'hff : s[7:0];
      u_mst.wr(t[i % 12], x);
      rchk(t[i % 12], exp_rd(t[i % 12], x));
      if (t[i % 12] == CHARGE_EN_ADDR) ep = x[3:1];
      chk("port_en", {5'h00, ep}, {5'h00, charge_port_en});
      if (i % 12 == 0) chk("len", x, manufacturer_text_length);
      if (i % 12 == 1) chk("plen", x, product_text_length);
      if (i % 12 == 2) chk("slen", x, serial_text_length);
    end
    $display("register test done");
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    foreach (t[i]) rchk(t[i], 8'h00);
    chk("port_en", 8'h00, {5'h00, charge_port_en});
    chk("len", 8'h00, manufacturer_text_length);
    chk("plen", 8'h00, product_text_length);
    chk("slen", 8'h00, serial_text_length);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
